//--- bench/smb_host_model.sv
// smbus host model: idle lines, and a wake burst that pulls both lines low
`timescale 1ns/1ns
module smb_host_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // wake request from the bench
  input wire logic wake_i,
  // bus lines
  output logic smb_clk_o,
  output logic smb_dat_o
);
  logic [3:0] low_cnt_reg;

  // ****************************************************************
  // wake burst
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= 4'h0;
    end else if (wake_i) begin
      low_cnt_reg <= 4'hf;
    end else if (low_cnt_reg != 4'h0) begin
      low_cnt_reg <= low_cnt_reg - 4'h1;
    end
  end

  // released lines sit at the pull-up level, so a burst ends in an active bus
  assign smb_clk_o = (low_cnt_reg == 4'h0);
  assign smb_dat_o = (low_cnt_reg == 4'h0);
endmodule // smb_host_model

//--- bench/tb_battery_power_mode_safety_sequencer.sv
// self-checking testbench for the power-mode and safety sequencer
`timescale 1ns/1ns
`include "power_seq_consts.svh"
module tb_battery_power_mode_safety_sequencer import power_seq_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] cell_mv = 16'h0e10;
  logic charger = 1'b0;
  fault_t fault = '0;
  logic second_fault = 1'b0;
  logic [1:0] ext_sw = 2'b00;
  logic button = 1'b0;
  logic [2:0] level = 3'h0;
  logic wake = 1'b0;
  logic smb_clk;
  logic smb_dat;
  fet_t fet;
  logic fuse;
  logic [4:0] seg;
  disp_t disp;
  pmode_t mode;
  logic safety_en;
  logic smb_tick;
  logic flash_wr;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic meas_tick;
  logic load = 1'b1;
  logic [17:0] cur = 18'h0;
  int fail_count = 0;
  int check_count = 0;
  int flash_cnt = 0;
  int gap = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  // measurement ticks shortened so that standby, counter and log are reached in the run
  defparam dut_u.u_tick.NORMAL_CYC = 100;
  defparam dut_u.u_tick.STBY_CYC = 800;

  power_seq dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .min_cell_mv_i(cell_mv),
    .cur_sample_i(cur), .load_active_i(load), .charger_present_i(charger), .fault_i(fault),
    .second_fault_i(second_fault), .external_switch_control_inputs_i(ext_sw), .smb_clk_i(smb_clk),
    .smb_dat_i(smb_dat), .gauge_display_button_i(button), .gauge_level_i(level), .fet_o(fet),
    .secondary_fuse_output_o(fuse), .gauge_seg_o(seg), .disp_kind_o(disp), .mode_o(mode), .safety_en_o(safety_en),
    .meas_tick_o(meas_tick), .smb_tick_o(smb_tick), .flash_wr_o(flash_wr), .irq_o(irq));

  smb_host_model host_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wake_i(wake), .smb_clk_o(smb_clk),
    .smb_dat_o(smb_dat));

  always @(posedge ref_clk_i) begin
    if (flash_wr === 1'b1) flash_cnt++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task end_of_test;
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t reg %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task cmp_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t pin %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t bus timeout", $time);
      end_of_test();
    end
  endtask

  task settle(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask

  task wait_mode(input pmode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 1000) begin
      @(posedge ref_clk_i);
      n++;
    end
    cmp_pin(8'(mode), 8'(m), "mode wait");
    if (mode !== m) end_of_test();
  endtask

  // waits for the next pulse of the chosen tick, gap holds the cycles waited
  task wait_pulse(input logic meas);
    gap = 0;
    do begin
      @(posedge ref_clk_i);
      gap++;
    end while ((meas ? meas_tick : smb_tick) !== 1'b1 && gap < 2000);
    if (gap >= 2000) begin
      fail_count++;
      $display("MISMATCH %0t tick timeout", $time);
      end_of_test();
    end
  endtask

  task tick_gap(input logic meas, input int exp);
    wait_pulse(meas);
    wait_pulse(meas);
    cmp_reg(32'(gap), 32'(exp), "tick gap");
  endtask

  initial begin
    #5000000;
    fail_count++;
    end_of_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, `OFS_UV_THR, 32'h0);
    cmp_reg(rd, 32'h09c4, "uv thr reset");
    apb(1'b0, `OFS_UV_REC, 32'h0);
    cmp_reg(rd, 32'h0a8c, "uv rec reset");
    apb(1'b0, `OFS_SNAP, 32'h0);
    cmp_reg(rd, 32'h4, "snap reset");
    apb(1'b0, 12'h034, 32'h0);
    cmp_reg(32'(er), 32'h1, "unmapped error");
    tick_gap(1'b0, 200);
    tick_gap(1'b1, 100);
    // switch control inputs, both polarities
    apb(1'b1, `OFS_CTRL, 32'h20);
    ext_sw <= 2'b01;
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h1, "ext chg block");
    ext_sw <= 2'b10;
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h2, "ext dsg block");
    apb(1'b1, `OFS_CTRL, 32'h23);
    ext_sw <= 2'b00;
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h0, "ext inverted");
    apb(1'b1, `OFS_CTRL, 32'h20);
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h3, "ext released");
    fault <= fault_t'(7'h02);
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h2, "dsg overcurrent");
    fault <= fault_t'(7'h40);
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h1, "cell overvoltage");
    fault <= fault_t'(7'h01);
    settle(4);
    cmp_pin(8'({fet.chg, fet.dsg}), 8'h0, "short circuit");
    fault <= fault_t'(7'h02);
    wait_pulse(1'b1);
    wait_pulse(1'b1);
    fault <= '0;
    apb(1'b0, `OFS_LOG_IDX, 32'h0);
    apb(1'b1, `OFS_LOG_IDX, 32'((rd[7:4] + 4'd9) % 10));
    apb(1'b0, `OFS_LOG_DATA, 32'h0);
    cmp_reg(rd, 32'h2, "last logged fault");
    cur <= 18'd3;
    wait_pulse(1'b1);
    wait_pulse(1'b1);
    cur <= 18'd10;
    wait_pulse(1'b1);
    cur <= 18'h0;
    apb(1'b0, `OFS_COULOMB, 32'h0);
    cmp_reg(rd, 32'd10, "coulomb snap band");
    // gauge and display kind
    level <= 3'h4;
    button <= 1'b1;
    settle(4);
    cmp_pin(8'(seg), 8'h0f, "gauge five");
    apb(1'b1, `OFS_CTRL, 32'h00);
    settle(4);
    cmp_pin(8'(seg), 8'h07, "gauge three");
    button <= 1'b0;
    settle(4);
    cmp_pin(8'(seg), 8'h00, "gauge off");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `OFS_CTRL, 32'(k * 4));
      settle(4);
      cmp_pin(8'(disp), 8'(k), "display kind");
    end
    // ship mode
    apb(1'b1, `OFS_SHIP_KEY, 32'h1234_5678);
    settle(4);
    cmp_pin(8'(mode), 8'(MODE_NORMAL), "wrong key");
    cmp_reg(32'(flash_cnt), 32'h0, "no flash write");
    apb(1'b1, `OFS_SHIP_KEY, `SHIP_KEY_VAL);
    wait_mode(MODE_SHIP);
    settle(2);
    cmp_pin(8'(fet), 8'h0, "ship switches");
    cmp_pin(8'(safety_en), 8'h0, "ship safety");
    cmp_reg(32'(flash_cnt), 32'h1, "ship flash write");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    cmp_reg(rd & 32'h8, 32'h8, "ship status");
    wake <= 1'b1;
    @(posedge ref_clk_i);
    wake <= 1'b0;
    wait_mode(MODE_NORMAL);
    settle(2);
    cmp_pin(8'(safety_en), 8'h1, "normal safety");
    // undervoltage shutdown
    apb(1'b1, `OFS_UV_THR, 32'd2000);
    apb(1'b0, `OFS_UV_THR, 32'h0);
    cmp_reg(rd, 32'h08fc, "uv thr clamp");
    cell_mv <= 16'd2400;
    charger <= 1'b1;
    settle(50);
    cmp_pin(8'(mode), 8'(MODE_NORMAL), "above thr");
    cell_mv <= 16'd2200;
    wait_mode(MODE_UV_SHUT);
    settle(2);
    cmp_pin(8'(fet), 8'h1, "uv precharge");
    cmp_pin(8'(safety_en), 8'h0, "uv safety");
    charger <= 1'b0;
    settle(4);
    cmp_pin(8'(fet), 8'h0, "uv no charger");
    cell_mv <= 16'd2600;
    settle(50);
    cmp_pin(8'(mode), 8'(MODE_UV_SHUT), "below recovery");
    cell_mv <= 16'd2800;
    wait_mode(MODE_NORMAL);
    cell_mv <= 16'h0e10;
    // standby after idle ticks, slow rate there, wake on load
    apb(1'b1, `OFS_IDLE_TIME, 32'h3);
    load <= 1'b0;
    wait_mode(MODE_STANDBY);
    tick_gap(1'b1, 800);
    cmp_pin(8'(safety_en), 8'h1, "standby safety");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    cmp_reg(rd & 32'h10, 32'h10, "standby status");
    load <= 1'b1;
    wait_mode(MODE_NORMAL);
    // fuse and interrupt
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `OFS_IRQ_STAT, 32'h1f);
    second_fault <= 1'b1;
    settle(4);
    second_fault <= 1'b0;
    settle(4);
    cmp_pin(8'(fuse), 8'h1, "fuse sticky");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    cmp_reg(rd & 32'h2, 32'h2, "fuse status");
    cmp_pin(8'(irq), 8'h0, "irq masked");
    apb(1'b1, `OFS_IRQ_MASK, 32'h1f);
    settle(2);
    cmp_pin(8'(irq), 8'h1, "mask effect");
    apb(1'b1, `OFS_IRQ_STAT, 32'h1f);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    cmp_reg(rd, 32'h0, "status cleared");
    settle(2);
    cmp_pin(8'(irq), 8'h0, "irq cleared");
    end_of_test();
  end
endmodule // tb_battery_power_mode_safety_sequencer

//--- rtl/power_seq.sv
// battery power-mode and protection sequencer with apb registers
// Functional notes
// - normal mode: measure, decide and update about once per second, safety on.
// - standby: same work at a much slower rate, safety still on.
// - enter standby after idle load time; leave on load activity.
// - ship: all switches open, safety off, slow voltage/temperature monitoring.
// - ship entered only by protected host command, never otherwise.
// - leave ship when smbus clock and data become active.
// - on ship entry store an environmental record to flash.
// - enter undervoltage shutdown below programmable 2.3 to 2.7 V threshold.
// - shutdown: charge/discharge open, safety off, precharge on with charger.
// - leave shutdown once cells exceed recovery threshold, 2.7 V typical.
// - first-level faults act by switching the protection switch drives.
// - second-level fault asserts fuse output, independent of first level; the code latches it only in normal and standby.
// - external switch inputs with programmable polarity operate switches.
// - drive 3 to 5 segment led gauge while button asserted; the code blanks it in undervoltage shutdown.
// - 18-bit coulomb counter ignores readings inside snap-to-zero band.
// - keep last 10 first-level faults, readable by host; the code logs fault_i on a tick only while a switch drive is still on.
// - smbus bit clock runs at nominal 100 khz.
// - display kind selected by stored configuration field.
`timescale 1ns/1ns
`include "power_seq_consts.svh"
module power_seq
  import power_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurements
  input wire logic [15:0] min_cell_mv_i,
  input wire logic [17:0] cur_sample_i,
  input wire logic load_active_i,
  input wire logic charger_present_i,
  input wire fault_t fault_i,
  input wire logic second_fault_i,
  input wire logic [1:0] external_switch_control_inputs_i,
  input wire logic smb_clk_i,
  input wire logic smb_dat_i,
  input wire logic gauge_display_button_i,
  input wire logic [2:0] gauge_level_i,
  // outputs
  output fet_t fet_o,
  output logic secondary_fuse_output_o,
  output logic [4:0] gauge_seg_o,
  output disp_t disp_kind_o,
  output pmode_t mode_o,
  output logic safety_en_o,
  output logic meas_tick_o,
  output logic smb_tick_o,
  output logic flash_wr_o,
  output logic irq_o
);
  // ****************************************************************
  // registers and state
  // ****************************************************************
  pmode_t mode_reg;
  logic [5:0] ctrl_reg;
  logic [15:0] uv_thr_reg, uv_rec_reg, snap_reg, idle_time_reg, idle_cnt_reg;
  logic [4:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic [17:0] coulomb_reg;
  logic [31:0] flash_rec_reg;
  logic [3:0] log_idx_reg, log_wp_reg;
  logic [6:0] log_mem [`LOG_DEPTH];
  logic ship_req, first_fault, tick_raw, smb_raw, smb_seen_reg;
  logic wr_en;
  logic [1:0] ext_active;

  assign wr_en = psel && penable && pwrite;
  assign first_fault = |fault_i;
  assign ship_req = wr_en && paddr == `OFS_SHIP_KEY && pwdata == `SHIP_KEY_VAL;

  function automatic logic [15:0] clamp_thr(input logic [15:0] v);
    if (v < `UV_THR_MIN) return `UV_THR_MIN;
    if (v > `UV_THR_MAX) return `UV_THR_MAX;
    return v;
  endfunction

  function automatic logic [4:0] bar_decode(input logic [2:0] lvl, input logic [1:0] segs);
    logic [4:0] m;
    m = 5'h1f >> (2'd2 - (segs > 2'd2 ? 2'd2 : segs));
    return 5'((5'h1f >> (3'd5 - (lvl > 3'd5 ? 3'd5 : lvl))) & m);
  endfunction

  power_seq_tick u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .slow_i(mode_reg != MODE_NORMAL),
    .meas_tick_o(tick_raw),
    .smb_tick_o(smb_raw)
  );

  // ****************************************************************
  // power mode sequencing
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_NORMAL;
      idle_cnt_reg <= 16'h0;
      smb_seen_reg <= 1'b0;
    end else begin
      smb_seen_reg <= smb_clk_i && smb_dat_i;
      unique case (mode_reg)
        MODE_NORMAL, MODE_STANDBY: begin
          if (min_cell_mv_i < uv_thr_reg) begin
            mode_reg <= MODE_UV_SHUT;
          end else if (ship_req) begin
            mode_reg <= MODE_SHIP;
          end else if (load_active_i) begin
            mode_reg <= MODE_NORMAL;
            idle_cnt_reg <= 16'h0;
          end else if (tick_raw && mode_reg == MODE_NORMAL) begin
            if (idle_cnt_reg + 16'h1 >= idle_time_reg) begin
              mode_reg <= MODE_STANDBY;
            end
            idle_cnt_reg <= idle_cnt_reg + 16'h1;
          end
        end
        MODE_SHIP: begin
          // line must idle low first, then return high
          if (smb_clk_i && smb_dat_i && !smb_seen_reg) begin
            mode_reg <= MODE_NORMAL;
            idle_cnt_reg <= 16'h0;
          end
        end
        MODE_UV_SHUT: begin
          if (min_cell_mv_i > uv_rec_reg) begin
            mode_reg <= MODE_NORMAL;
            idle_cnt_reg <= 16'h0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // protection outputs
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fet_o <= '0;
      safety_en_o <= 1'b0;
      mode_o <= MODE_NORMAL;
    end else begin
      mode_o <= mode_reg;
      unique case (mode_reg)
        MODE_SHIP: begin
          fet_o <= '0;
          safety_en_o <= 1'b0;
        end
        MODE_UV_SHUT: begin
          fet_o <= '{chg: 1'b0, dsg: 1'b0, pre: charger_present_i};
          safety_en_o <= 1'b0;
        end
        MODE_NORMAL, MODE_STANDBY: begin
          safety_en_o <= 1'b1;
          fet_o.chg <= !(fault_i.cell_ov || fault_i.pack_ov || fault_i.ocur_chg || fault_i.short_circ)
            && !ext_active[0];
          fet_o.dsg <= !(fault_i.cell_uv || fault_i.pack_uv || fault_i.ocur_dsg || fault_i.short_circ)
            && !ext_active[1];
          fet_o.pre <= !first_fault && !ext_active[0];
        end
      endcase
    end
  end

  assign ext_active = external_switch_control_inputs_i ^ ctrl_reg[`CTRL_POL_LSB +: 2];

  // fuse latches for good, independent of first-level path
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      secondary_fuse_output_o <= 1'b0;
    end else if (second_fault_i && mode_reg inside {MODE_NORMAL, MODE_STANDBY}) begin
      secondary_fuse_output_o <= 1'b1;
    end
  end

  // ****************************************************************
  // ticks, ship record, gauge
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meas_tick_o <= 1'b0;
      smb_tick_o <= 1'b0;
      flash_wr_o <= 1'b0;
      flash_rec_reg <= 32'h0;
    end else begin
      meas_tick_o <= tick_raw && mode_reg != MODE_UV_SHUT;
      smb_tick_o <= smb_raw;
      flash_wr_o <= ship_req && mode_reg inside {MODE_NORMAL, MODE_STANDBY}
        && !(min_cell_mv_i < uv_thr_reg);
      if (ship_req && mode_reg inside {MODE_NORMAL, MODE_STANDBY}) begin
        flash_rec_reg <= {min_cell_mv_i, coulomb_reg[17:2]};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gauge_seg_o <= 5'h0;
      disp_kind_o <= DISP_LED;
    end else begin
      disp_kind_o <= disp_t'(ctrl_reg[`CTRL_DISP_LSB +: 2]);
      gauge_seg_o <= gauge_display_button_i && mode_reg != MODE_UV_SHUT
        ? bar_decode(gauge_level_i, ctrl_reg[`CTRL_SEG_LSB +: 2]) : 5'h0;
    end
  end

  // ****************************************************************
  // coulomb counter and fault log
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coulomb_reg <= 18'h0;
    end else if (tick_raw) begin
      if (!((cur_sample_i[17] ? 18'(-cur_sample_i) : cur_sample_i) <= {2'b0, snap_reg})) begin
        coulomb_reg <= coulomb_reg + cur_sample_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      log_wp_reg <= 4'h0;
    end else if (first_fault && fet_o != '0 && safety_en_o && mode_reg inside {MODE_NORMAL, MODE_STANDBY}
        && tick_raw) begin
      log_wp_reg <= log_wp_reg == 4'(`LOG_DEPTH - 1) ? 4'h0 : log_wp_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (first_fault && fet_o != '0 && safety_en_o && mode_reg inside {MODE_NORMAL, MODE_STANDBY} && tick_raw) begin
      log_mem[log_wp_reg] <= fault_i;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign irq_set = {mode_reg == MODE_NORMAL && load_active_i == 1'b0 && tick_raw
                      && idle_cnt_reg + 16'h1 >= idle_time_reg,
                    ship_req, min_cell_mv_i < uv_thr_reg && mode_reg inside {MODE_NORMAL, MODE_STANDBY},
                    second_fault_i, first_fault};

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= 5'h0;
      irq_o <= 1'b0;
    end else begin
      // set wins over a simultaneous write-one clear
      irq_stat_reg <= (irq_stat_reg & ~(wr_en && paddr == `OFS_IRQ_STAT ? pwdata[4:0] : 5'h0)) | irq_set;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // apb register file
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= 6'h0;
      irq_mask_reg <= 5'h0;
      uv_thr_reg <= `RST_UV_THR;
      uv_rec_reg <= `RST_UV_REC;
      snap_reg <= `RST_SNAP;
      idle_time_reg <= `RST_IDLE_TIME;
      log_idx_reg <= 4'h0;
    end else if (wr_en) begin
      unique case (paddr)
        `OFS_CTRL: ctrl_reg <= pwdata[5:0];
        `OFS_IRQ_MASK: irq_mask_reg <= pwdata[4:0];
        `OFS_UV_THR: uv_thr_reg <= clamp_thr(pwdata[15:0]);
        `OFS_UV_REC: uv_rec_reg <= pwdata[15:0];
        `OFS_SNAP: snap_reg <= pwdata[15:0];
        `OFS_IDLE_TIME: idle_time_reg <= pwdata[15:0];
        `OFS_LOG_IDX: log_idx_reg <= pwdata[3:0] < 4'(`LOG_DEPTH) ? pwdata[3:0] : 4'h0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > `OFS_FLASH_REC);
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `OFS_CTRL: prdata <= {26'h0, ctrl_reg};
          `OFS_MODE: prdata <= {28'h0, log_wp_reg == 4'h0 ? 1'b0 : 1'b1, 1'b0, mode_reg};
          `OFS_IRQ_STAT: prdata <= {27'h0, irq_stat_reg};
          `OFS_IRQ_MASK: prdata <= {27'h0, irq_mask_reg};
          `OFS_UV_THR: prdata <= {16'h0, uv_thr_reg};
          `OFS_UV_REC: prdata <= {16'h0, uv_rec_reg};
          `OFS_SNAP: prdata <= {16'h0, snap_reg};
          `OFS_COULOMB: prdata <= {{14{coulomb_reg[17]}}, coulomb_reg};
          `OFS_IDLE_TIME: prdata <= {16'h0, idle_time_reg};
          `OFS_LOG_IDX: prdata <= {24'h0, log_wp_reg, log_idx_reg};
          `OFS_LOG_DATA: prdata <= {25'h0, log_mem[log_idx_reg]};
          `OFS_FLASH_REC: prdata <= flash_rec_reg;
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_ship_opens: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_reg == MODE_SHIP |=> fet_o == '0 && !safety_en_o) else $error("switches not open in ship");
  chk_ship_cmd: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(mode_reg == MODE_SHIP) |-> $past(ship_req)) else $error("ship entered without command");
  chk_uv_entry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_reg inside {MODE_NORMAL, MODE_STANDBY} && min_cell_mv_i < uv_thr_reg |=> mode_reg == MODE_UV_SHUT)
    else $error("undervoltage shutdown missed");
  chk_uv_precharge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_reg == MODE_UV_SHUT |=> !fet_o.chg && !fet_o.dsg && fet_o.pre == $past(charger_present_i))
    else $error("shutdown switch state wrong");
  chk_uv_exit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_reg == MODE_UV_SHUT && min_cell_mv_i > uv_rec_reg |=> mode_reg == MODE_NORMAL)
    else $error("shutdown recovery missed");
  chk_fuse_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    secondary_fuse_output_o |=> secondary_fuse_output_o) else $error("fuse output released");
  chk_short_opens: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fault_i.short_circ && mode_reg == MODE_NORMAL |=> !fet_o.chg && !fet_o.dsg)
    else $error("short circuit left switches closed");
  chk_gauge_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !gauge_display_button_i |=> gauge_seg_o == 5'h0) else $error("gauge lit without button");
  chk_load_wake: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_reg == MODE_STANDBY && load_active_i && min_cell_mv_i >= uv_thr_reg && !ship_req
    |=> mode_reg == MODE_NORMAL) else $error("no wake on load");
endmodule // power_seq

//--- rtl/power_seq_consts.svh
// constants for the battery power-mode and safety sequencer
`ifndef POWER_SEQ_CONSTS_SVH
`define POWER_SEQ_CONSTS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_MODE 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00c
`define OFS_UV_THR 12'h010
`define OFS_UV_REC 12'h014
`define OFS_SNAP 12'h018
`define OFS_COULOMB 12'h01c
`define OFS_IDLE_TIME 12'h020
`define OFS_SHIP_KEY 12'h024
`define OFS_LOG_IDX 12'h028
`define OFS_LOG_DATA 12'h02c
`define OFS_FLASH_REC 12'h030

// ****************************************************************
// reset values (cell voltages in mV)
// ****************************************************************
`define RST_UV_THR 16'h09c4
`define RST_UV_REC 16'h0a8c
`define UV_THR_MIN 16'h08fc
`define UV_THR_MAX 16'h0a8c
`define RST_SNAP 16'h0004
`define RST_IDLE_TIME 16'h000a
`define SHIP_KEY_VAL 32'h5a5a_c3c3

// ****************************************************************
// ctrl fields
// ****************************************************************
`define CTRL_POL_LSB 0
`define CTRL_DISP_LSB 2
`define CTRL_SEG_LSB 4

// ****************************************************************
// irq status bits
// ****************************************************************
`define IRQ_FIRST 0
`define IRQ_FUSE 1
`define IRQ_UV 2
`define IRQ_SHIP 3
`define IRQ_STBY 4

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 20000000
`define TICK_NORMAL_MS 1000
`define TICK_STBY_MS 8000
`define SMB_KHZ 100
`define LOG_DEPTH 10
`endif

//--- rtl/power_seq_pkg.sv
// types of the battery power-mode and safety sequencer
package power_seq_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_STANDBY, MODE_SHIP, MODE_UV_SHUT} pmode_t;
  typedef enum logic [1:0] {DISP_LED, DISP_LCD, DISP_EPD, DISP_NONE} disp_t;
  typedef struct packed {
    logic chg;
    logic dsg;
    logic pre;
  } fet_t;
  typedef struct packed {
    logic cell_ov;
    logic cell_uv;
    logic pack_ov;
    logic pack_uv;
    logic ocur_chg;
    logic ocur_dsg;
    logic short_circ;
  } fault_t;
endpackage

//--- rtl/power_seq_tick.sv
// rate divider for measurement ticks and smbus bit clock enable
`timescale 1ns/1ns
`include "power_seq_consts.svh"
module power_seq_tick
  import power_seq_pkg::*;
#(
  parameter int unsigned NORMAL_CYC = `CLK_HZ / 1000 * `TICK_NORMAL_MS,
  parameter int unsigned STBY_CYC = `CLK_HZ / 1000 * `TICK_STBY_MS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // rate select
  input wire logic slow_i,
  // enables
  output logic meas_tick_o,
  output logic smb_tick_o
);
  localparam int unsigned SMB_CYC = `CLK_HZ / (`SMB_KHZ * 1000);
  logic [31:0] meas_cnt_reg;
  logic [15:0] smb_cnt_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meas_cnt_reg <= 32'h0;
      meas_tick_o <= 1'b0;
    end else if (meas_cnt_reg >= (slow_i ? STBY_CYC - 1 : NORMAL_CYC - 1)) begin
      meas_cnt_reg <= 32'h0;
      meas_tick_o <= 1'b1;
    end else begin
      meas_cnt_reg <= meas_cnt_reg + 32'h1;
      meas_tick_o <= 1'b0;
    end
  end

  // 100 khz smbus bit clock enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smb_cnt_reg <= 16'h0;
      smb_tick_o <= 1'b0;
    end else if (smb_cnt_reg == 16'(SMB_CYC - 1)) begin
      smb_cnt_reg <= 16'h0;
      smb_tick_o <= 1'b1;
    end else begin
      smb_cnt_reg <= smb_cnt_reg + 16'h1;
      smb_tick_o <= 1'b0;
    end
  end
endmodule // power_seq_tick
